/* common/tuner_i2c_pkg.sv */
// shared constants and types for the tuner two-wire register port
package tuner_i2c_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam int NUM_REGS = 22;
	localparam logic [7:0] IDX_OSCILLATOR_BAND_SELECT = 8'h00;
	localparam logic [7:0] IDX_DIVIDER_INTEGER = 8'h01;
	localparam logic [7:0] IDX_DIVIDER_FRACTION_HIGH = 8'h02;
	localparam logic [7:0] IDX_DIVIDER_FRACTION_MID = 8'h03;
	localparam logic [7:0] IDX_DIVIDER_FRACTION_LOW = 8'h04;
	localparam logic [7:0] IDX_RECEIVE_MODE_CONTROL = 8'h05;
	localparam logic [7:0] IDX_TRACKING_SERIES_CAP = 8'h06;
	localparam logic [7:0] IDX_TRACKING_PARALLEL_CAP = 8'h07;
	localparam logic [7:0] IDX_BLOCK_POWER_DOWN = 8'h08;
	localparam logic [7:0] IDX_REFERENCE_CONFIG = 8'h09;
	localparam logic [7:0] IDX_AUTOSELECT_CONFIG = 8'h0a;
	localparam logic [7:0] IDX_POWER_DETECT_CONFIG_A = 8'h0b;
	localparam logic [7:0] IDX_POWER_DETECT_CONFIG_B = 8'h0c;
	localparam logic [7:0] IDX_FILTER_CENTER_ADJUST = 8'h0d;
	localparam logic [7:0] IDX_ROM_INDEX = 8'h0e;
	localparam logic [7:0] IDX_IMAGE_REJECT_TRIM = 8'h0f;
	localparam logic [7:0] IDX_ROM_READBACK = 8'h10;
	localparam logic [7:0] IDX_AUTOSELECT_STATUS = 8'h11;
	localparam logic [7:0] IDX_GENERAL_STATUS = 8'h12;
	localparam logic [7:0] IDX_BIAS_ADJUST = 8'h13;
	localparam logic [7:0] IDX_TEST_RESERVED = 8'h14;
	localparam logic [7:0] IDX_ROM_WRITE_DATA = 8'h15;
	// writable bits per index (last entry is index 0); zero marks read-only or reserved
	localparam logic [NUM_REGS-1:0][7:0] WRITE_MASK = {
		8'hff, 8'h00, 8'h7f, 8'h00, 8'h00, 8'h00, 8'hff, 8'h0f, 8'h3f, 8'h07, 8'hff,
		8'hff, 8'h1f, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
	localparam logic [7:0] GENERAL_STATUS_MASK = 8'h3f;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ****************************************
	// slave address and strap
	// ****************************************
	localparam logic [6:0] ADDR_BASE7 = 7'h60;
	localparam logic [1:0] STRAP_INVALID = 2'h3;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int POWERUP_WAIT_NS = 100000;
	localparam int POWERUP_CYCLES = (POWERUP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ****************************************
	// state encodings
	// ****************************************
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_RX = 3'h1,
		S_RX_ACK = 3'h2,
		S_TX = 3'h3,
		S_TX_ACK = 3'h4
	} slave_state_type;
	typedef enum logic [1:0] {
		K_ADDR = 2'h0,
		K_INDEX = 2'h1,
		K_DATA = 2'h2
	} byte_kind_type;
	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_START = 2'h1,
		M_BIT = 2'h2,
		M_STOP = 2'h3
	} master_state_type;
	typedef enum logic [2:0] {
		G_ADDR_W = 3'h0,
		G_INDEX = 3'h1,
		G_DATA_W = 3'h2,
		G_ADDR_R = 3'h3,
		G_DATA_R = 3'h4
	} master_stage_type;
endpackage

/* common/tuner_i2c_if.sv */
// two-wire link between the bus master and the tuner register port
interface tuner_i2c_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;
	// open-drain wire with pull-up: any enabled low driver wins
	assign scl = ~(m_scl_oe & ~m_scl_o);
	assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
	modport device (input scl, input sda, output s_sda_o, output s_sda_oe);
	modport master (input scl, input sda, output m_scl_o, output m_scl_oe,
		output m_sda_o, output m_sda_oe);
endinterface

/* design/tuner_i2c_slave.sv */
// device end: two-wire slave with the tuner register file
//
// Summary of operation
// - receiver pulls data low in ninth slot
// - not-acknowledge leaves data released in ninth slot
// - master abandons failed transfer, retries later
// - address byte with direction follows each start
// - strap selects one of three slave addresses
// - watch for start plus address, then acknowledge
// - write sends index then data, msb first
// - acknowledge stored byte, then advance pointer
// - write stays open until stop
// - read: write index, repeated start, read address
// - transmit selected register msb first
// - master ack fetches next; nack and stop end
// - eighteen configuration registers read back
// - status and rom readback are read-only
// - no typical values loaded at power-up
// - master writes all registers after power-up wait (the bench first writes only registers 0 to 2)
// - then rewrite channel registers zero to four
// - write in ascending index order
// - map spans 22 eight-bit entries
// - fraction low write starts oscillator autoselect
// - data stable while clock high, nine clocks
// - start and stop are data edges, clock high
module tuner_i2c_slave (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// two-wire link
	tuner_i2c_if.device link,
	// address strap, decoded from the three-state pin
	input wire logic address_strap_bit_hi,
	input wire logic address_strap_bit_lo,
	// read-only sources
	input wire logic [7:0] rom_readback_in,
	input wire logic [7:0] autoselect_status_in,
	input wire logic [7:0] general_status_in,
	// register file and write events
	output logic [tuner_i2c_pkg::NUM_REGS-1:0][7:0] config_regs,
	output logic reg_write_pulse,
	output logic [7:0] reg_write_index,
	output logic [7:0] reg_write_data,
	output logic oscillator_autoselect
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [2:0] scl_s; // pin synchronisers, bit 0 first
		logic [2:0] sda_s;
		logic [1:0] strap_s1;
		logic [1:0] strap_s2;
		logic [1:0] strap_s3;
		logic scl_f; // filtered levels
		logic sda_f;
		logic [1:0] strap;
		tuner_i2c_pkg::slave_state_type state;
		tuner_i2c_pkg::byte_kind_type kind;
		logic go_tx; // after this ack, start sending
		logic acked; // master ack seen in ninth slot
		logic [3:0] cnt; // bit counter within a byte
		logic [7:0] shreg; // shift register, both ways
		logic [7:0] ptr; // register pointer
		logic sda_oe; // pulls data low while set
		logic [tuner_i2c_pkg::NUM_REGS-1:0][7:0] regs;
		logic wr_pulse;
		logic [7:0] wr_index;
		logic [7:0] wr_data;
		logic autosel;
	} slave_regs_type;

	slave_regs_type r_reg;
	slave_regs_type r_next;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic addr_match;
	logic [7:0] load_byte; // byte the pointer selects, loaded for sending

	// ****************************************
	// read mux
	// ****************************************
	// out-of-range index reads zero rather than wrapping
	function automatic logic [7:0] read_value(input logic [7:0] idx,
		input logic [tuner_i2c_pkg::NUM_REGS-1:0][7:0] regs);
		logic [7:0] v;
		v = 8'h00;
		if (idx == tuner_i2c_pkg::IDX_ROM_READBACK) begin
			v = rom_readback_in;
		end else if (idx == tuner_i2c_pkg::IDX_AUTOSELECT_STATUS) begin
			v = autoselect_status_in;
		end else if (idx == tuner_i2c_pkg::IDX_GENERAL_STATUS) begin
			v = general_status_in & tuner_i2c_pkg::GENERAL_STATUS_MASK;
		end else if (idx < 8'(tuner_i2c_pkg::NUM_REGS)) begin
			v = regs[idx[4:0]];
		end
		return v;
	endfunction

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		r_next = r_reg;
		r_next.wr_pulse = 1'b0;
		r_next.autosel = 1'b0;
		// a function result cannot be bit-selected, so it is held here
		load_byte = read_value(r_reg.ptr, r_reg.regs);
		// three-stage synchronisers; a level counts once stages two and three agree
		r_next.scl_s = {r_reg.scl_s[1:0], link.scl};
		r_next.sda_s = {r_reg.sda_s[1:0], link.sda};
		r_next.strap_s1 = {address_strap_bit_hi, address_strap_bit_lo};
		r_next.strap_s2 = r_reg.strap_s1;
		r_next.strap_s3 = r_reg.strap_s2;
		if (r_reg.scl_s[1] == r_reg.scl_s[2]) begin
			r_next.scl_f = r_reg.scl_s[2];
		end
		if (r_reg.sda_s[1] == r_reg.sda_s[2]) begin
			r_next.sda_f = r_reg.sda_s[2];
		end
		if (r_reg.strap_s2 == r_reg.strap_s3) begin
			r_next.strap = r_reg.strap_s3;
		end
		scl_rise = ~r_reg.scl_f & r_next.scl_f;
		scl_fall = r_reg.scl_f & ~r_next.scl_f;
		// data edge with clock high both before and after
		start_seen = r_reg.scl_f & r_next.scl_f & r_reg.sda_f & ~r_next.sda_f;
		stop_seen = r_reg.scl_f & r_next.scl_f & ~r_reg.sda_f & r_next.sda_f;
		// strap 2'h3 matches nothing: the pin has only three states
		addr_match = (r_reg.shreg[7:1] == (tuner_i2c_pkg::ADDR_BASE7 | {5'h00, r_reg.strap}))
			&& (r_reg.strap != tuner_i2c_pkg::STRAP_INVALID);
		if (stop_seen) begin
			// stop closes any open write or read
			r_next.state = tuner_i2c_pkg::S_IDLE;
			r_next.sda_oe = 1'b0;
		end else if (start_seen) begin
			// start or repeated start is honoured in every state
			r_next.state = tuner_i2c_pkg::S_RX;
			r_next.kind = tuner_i2c_pkg::K_ADDR;
			r_next.cnt = 4'h0;
			r_next.sda_oe = 1'b0;
		end else begin
			case (r_reg.state)
				tuner_i2c_pkg::S_IDLE: begin
					r_next.sda_oe = 1'b0;
				end
				tuner_i2c_pkg::S_RX: begin
					if (scl_rise) begin
						// sample while clock high, msb first
						r_next.shreg = {r_reg.shreg[6:0], r_next.sda_f};
						r_next.cnt = r_reg.cnt + 4'h1;
					end else if (scl_fall && r_reg.cnt == 4'h8) begin
						r_next.state = tuner_i2c_pkg::S_RX_ACK;
						r_next.go_tx = 1'b0;
						case (r_reg.kind)
							tuner_i2c_pkg::K_ADDR: begin
								if (addr_match) begin
									// pull low for the whole ninth clock
									r_next.sda_oe = 1'b1;
									r_next.go_tx = r_reg.shreg[0];
									r_next.kind = tuner_i2c_pkg::K_INDEX;
								end else begin
									// another slave's byte: wait for next start
									r_next.state = tuner_i2c_pkg::S_IDLE;
								end
							end
							tuner_i2c_pkg::K_INDEX: begin
								r_next.ptr = r_reg.shreg;
								r_next.sda_oe = 1'b1;
								r_next.kind = tuner_i2c_pkg::K_DATA;
							end
							default: begin
								// read-only, reserved and unmapped entries are not stored
								if (r_reg.ptr < 8'(tuner_i2c_pkg::NUM_REGS)
									&& tuner_i2c_pkg::WRITE_MASK[r_reg.ptr[4:0]] != 8'h00) begin
									r_next.regs[r_reg.ptr[4:0]] = r_reg.shreg
										& tuner_i2c_pkg::WRITE_MASK[r_reg.ptr[4:0]];
									r_next.wr_pulse = 1'b1;
									r_next.wr_index = r_reg.ptr;
									r_next.wr_data = r_reg.shreg;
									r_next.sda_oe = 1'b1;
									if (r_reg.ptr == tuner_i2c_pkg::IDX_DIVIDER_FRACTION_LOW) begin
										r_next.autosel = 1'b1;
									end
								end else begin
									// released line signals not-acknowledge
									r_next.sda_oe = 1'b0;
								end
								r_next.ptr = r_reg.ptr + 8'h01;
							end
						endcase
					end
				end
				tuner_i2c_pkg::S_RX_ACK: begin
					if (scl_fall) begin
						r_next.cnt = 4'h0;
						if (r_reg.go_tx) begin
							// first byte of a read comes from the pointer
							r_next.shreg = load_byte;
							r_next.ptr = r_reg.ptr + 8'h01;
							r_next.sda_oe = ~load_byte[7];
							r_next.state = tuner_i2c_pkg::S_TX;
						end else begin
							r_next.sda_oe = 1'b0;
							r_next.state = tuner_i2c_pkg::S_RX;
						end
					end
				end
				tuner_i2c_pkg::S_TX: begin
					// the bit advances after each clock-high phase and is put out
					// once the clock is low again, so the line never moves while high
					if (scl_fall) begin
						if (r_reg.cnt == 4'h7) begin
							r_next.sda_oe = 1'b0;
							r_next.state = tuner_i2c_pkg::S_TX_ACK;
						end else begin
							r_next.cnt = r_reg.cnt + 4'h1;
							r_next.shreg = {r_reg.shreg[6:0], 1'b0};
							r_next.sda_oe = ~r_reg.shreg[6];
						end
					end
				end
				tuner_i2c_pkg::S_TX_ACK: begin
					if (scl_rise) begin
						r_next.acked = ~r_next.sda_f;
					end else if (scl_fall) begin
						r_next.cnt = 4'h0;
						if (r_reg.acked) begin
							r_next.shreg = load_byte;
							r_next.ptr = r_reg.ptr + 8'h01;
							r_next.sda_oe = ~load_byte[7];
							r_next.state = tuner_i2c_pkg::S_TX;
						end else begin
							// nack: stay off the line until start or stop
							r_next.state = tuner_i2c_pkg::S_IDLE;
						end
					end
				end
				default: begin
					r_next.state = tuner_i2c_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// state register
	// ****************************************
	// register contents get a defined zero, no typical values are loaded
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			r_reg <= '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
				state: tuner_i2c_pkg::S_IDLE, kind: tuner_i2c_pkg::K_ADDR,
				regs: {tuner_i2c_pkg::NUM_REGS{tuner_i2c_pkg::REG_RESET}}, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign link.s_sda_o = 1'b0;
	assign link.s_sda_oe = r_reg.sda_oe;
	assign config_regs = r_reg.regs;
	assign reg_write_pulse = r_reg.wr_pulse;
	assign reg_write_index = r_reg.wr_index;
	assign reg_write_data = r_reg.wr_data;
	assign oscillator_autoselect = r_reg.autosel;
endmodule

/* design/tuner_i2c_master.sv */
// master end: drives the two-wire link to write and read tuner registers
module tuner_i2c_master #(
	parameter logic [6:0] SLAVE_ADDR = tuner_i2c_pkg::ADDR_BASE7
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// two-wire link
	tuner_i2c_if.master link,
	// command port
	input wire logic cmd_valid,
	input wire logic cmd_read,
	input wire logic [7:0] cmd_index,
	input wire logic [4:0] cmd_len,
	output logic cmd_ready,
	// write data, next byte requested by wr_take
	input wire logic [7:0] wr_data,
	output logic wr_take,
	// read data and completion
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic done,
	output logic nack_error
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [2:0] sda_s; // data-line synchroniser
		logic sda_f;
		logic [9:0] pwr_cnt; // power-up wait
		logic [4:0] div; // quarter-bit divider
		logic [1:0] q; // quarter within a bit
		tuner_i2c_pkg::master_state_type state;
		tuner_i2c_pkg::master_stage_type stage;
		logic [3:0] bitn;
		logic [7:0] txbyte;
		logic [7:0] rxbyte;
		logic [4:0] remaining;
		logic read;
		logic [7:0] index;
		logic nack;
		logic scl_oe;
		logic sda_oe;
		logic ready;
		logic take;
		logic rvalid;
		logic [7:0] rdata;
		logic fin;
		logic err;
	} master_regs_type;

	master_regs_type r_reg;
	master_regs_type r_next;
	logic tick;
	logic tx;

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		r_next = r_reg;
		r_next.take = 1'b0;
		r_next.rvalid = 1'b0;
		r_next.fin = 1'b0;
		r_next.sda_s = {r_reg.sda_s[1:0], link.sda};
		if (r_reg.sda_s[1] == r_reg.sda_s[2]) begin
			r_next.sda_f = r_reg.sda_s[2];
		end
		// commands only after the supply has settled
		if (r_reg.pwr_cnt != 10'(tuner_i2c_pkg::POWERUP_CYCLES)) begin
			r_next.pwr_cnt = r_reg.pwr_cnt + 10'h001;
		end else if (r_reg.state == tuner_i2c_pkg::M_IDLE) begin
			r_next.ready = 1'b1;
		end
		tick = (r_reg.div == 5'(tuner_i2c_pkg::QUARTER_CYCLES - 1));
		r_next.div = tick ? 5'h00 : r_reg.div + 5'h01;
		tx = (r_reg.stage != tuner_i2c_pkg::G_DATA_R);
		if (tick) begin
			r_next.q = r_reg.q + 2'h1;
		end
		case (r_reg.state)
			tuner_i2c_pkg::M_IDLE: begin
				r_next.div = 5'h00;
				r_next.q = 2'h0;
				if (cmd_valid && r_reg.ready) begin
					r_next.ready = 1'b0;
					r_next.err = 1'b0;
					r_next.read = cmd_read;
					r_next.index = cmd_index;
					r_next.remaining = cmd_len;
					r_next.stage = tuner_i2c_pkg::G_ADDR_W;
					r_next.state = tuner_i2c_pkg::M_START;
				end
			end
			tuner_i2c_pkg::M_START: begin
				// release data, raise clock, pull data low, lower clock
				if (tick) begin
					case (r_reg.q)
						2'h0: r_next.sda_oe = 1'b0;
						2'h1: r_next.scl_oe = 1'b0;
						2'h2: r_next.sda_oe = 1'b1;
						default: begin
							r_next.scl_oe = 1'b1;
							r_next.bitn = 4'h0;
							r_next.state = tuner_i2c_pkg::M_BIT;
							r_next.txbyte = {SLAVE_ADDR,
								r_reg.stage == tuner_i2c_pkg::G_ADDR_R};
						end
					endcase
				end
			end
			tuner_i2c_pkg::M_BIT: begin
				if (tick) begin
					case (r_reg.q)
						2'h0: begin
							// data only changes while the clock is low
							if (r_reg.bitn != 4'h8) begin
								r_next.sda_oe = tx & ~r_reg.txbyte[7];
							end else begin
								// ack all but the last read byte
								r_next.sda_oe = ~tx & (r_reg.remaining > 5'h01);
							end
						end
						2'h1: r_next.scl_oe = 1'b0;
						2'h2: begin
							if (r_reg.bitn != 4'h8) begin
								r_next.rxbyte = {r_reg.rxbyte[6:0], r_reg.sda_f};
								r_next.txbyte = {r_reg.txbyte[6:0], 1'b0};
							end else begin
								r_next.nack = tx & r_reg.sda_f;
							end
						end
						default: begin
							r_next.scl_oe = 1'b1;
							r_next.bitn = r_reg.bitn + 4'h1;
							if (r_reg.bitn == 4'h8) begin
								r_next.bitn = 4'h0;
								// data is left alone here: it moves a quarter later, not with the clock fall
								if (r_reg.nack && tx) begin
									// failed transfer: abandon, caller retries
									r_next.err = 1'b1;
									r_next.state = tuner_i2c_pkg::M_STOP;
								end else begin
									case (r_reg.stage)
										tuner_i2c_pkg::G_ADDR_W: begin
											r_next.stage = tuner_i2c_pkg::G_INDEX;
											r_next.txbyte = r_reg.index;
										end
										tuner_i2c_pkg::G_INDEX: begin
											if (r_reg.read) begin
												r_next.stage = tuner_i2c_pkg::G_ADDR_R;
												r_next.state = tuner_i2c_pkg::M_START;
											end else begin
												r_next.stage = tuner_i2c_pkg::G_DATA_W;
												r_next.txbyte = wr_data;
												r_next.take = 1'b1;
											end
										end
										tuner_i2c_pkg::G_DATA_W: begin
											if (r_reg.remaining <= 5'h01) begin
												r_next.state = tuner_i2c_pkg::M_STOP;
											end else begin
												r_next.remaining = r_reg.remaining - 5'h01;
												r_next.txbyte = wr_data;
												r_next.take = 1'b1;
											end
										end
										tuner_i2c_pkg::G_ADDR_R: begin
											r_next.stage = tuner_i2c_pkg::G_DATA_R;
										end
										default: begin
											r_next.rvalid = 1'b1;
											r_next.rdata = r_reg.rxbyte;
											r_next.remaining = r_reg.remaining - 5'h01;
											if (r_reg.remaining <= 5'h01) begin
												r_next.state = tuner_i2c_pkg::M_STOP;
											end
										end
									endcase
								end
							end
						end
					endcase
				end
			end
			default: begin
				// pull data low, raise clock, release data, finish
				if (tick) begin
					case (r_reg.q)
						2'h0: r_next.sda_oe = 1'b1;
						2'h1: r_next.scl_oe = 1'b0;
						2'h2: r_next.sda_oe = 1'b0;
						default: begin
							r_next.fin = 1'b1;
							r_next.state = tuner_i2c_pkg::M_IDLE;
						end
					endcase
				end
			end
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			r_reg <= '{sda_s: 3'h7, sda_f: 1'b1, state: tuner_i2c_pkg::M_IDLE,
				stage: tuner_i2c_pkg::G_ADDR_W, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign link.m_scl_o = 1'b0;
	assign link.m_scl_oe = r_reg.scl_oe;
	assign link.m_sda_o = 1'b0;
	assign link.m_sda_oe = r_reg.sda_oe;
	assign cmd_ready = r_reg.ready;
	assign wr_take = r_reg.take;
	assign rd_valid = r_reg.rvalid;
	assign rd_data = r_reg.rdata;
	assign done = r_reg.fin;
	assign nack_error = r_reg.err;
endmodule

/* tb/tuner_i2c_register_port_asserts.sv */
// concurrent checks on the two-wire link between master and tuner port
module tuner_i2c_register_port_asserts (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// resolved wires and drivers
	input wire logic scl,
	input wire logic sda,
	input wire logic m_scl_oe,
	input wire logic m_sda_oe,
	input wire logic s_sda_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// link timing
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// slave data held across the whole clock high phase
	AST_SLAVE_STABLE_HIGH: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
		else $error("slave data moved while clock high");
	// slave moves data only just after a clock fall
	AST_SLAVE_EDGE: assert property ($changed(s_sda_oe) |-> !scl && $past(scl, 6))
		else $error("slave data moved away from clock fall");
	// transmitter released while the slave drives its slot
	AST_ACK_RELEASED: assert property (s_sda_oe && $rose(scl) |-> !m_sda_oe)
		else $error("master drove data during slave slot");
	// master data set a quarter after clock fall
	AST_MASTER_EDGE: assert property ($changed(m_sda_oe) && !scl |-> !$past(scl, 20))
		else $error("master data moved too early");
	// start is followed by the clock falling a quarter later
	AST_START_FALL: assert property ($fell(sda) && scl |-> ##[20:30] !scl)
		else $error("clock did not fall after start");
	// clock stays high for eight cycles after stop
	AST_STOP_IDLE: assert property ($rose(sda) && scl |-> scl [*8])
		else $error("clock left idle after stop");
	// slave released once stop is seen
	AST_STOP_RELEASED: assert property ($rose(sda) && scl |-> !s_sda_oe [*4])
		else $error("slave held data after stop");
	// clock high phase lasts at least eight cycles
	AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	// main scenarios reached
	cover property ($fell(sda) && scl);
	cover property ($rose(sda) && scl);
	cover property (s_sda_oe && $rose(scl));
endmodule

/* tb/test_tuner_i2c_register_port.sv */
// self-checking bench: master and tuner port joined over one link
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_tuner_i2c_register_port;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// signals
	// ****************************************
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [1:0] strap = 2'h0; // strap code 00 matches master address
	logic [7:0] rom_in = 8'h5a;
	logic [7:0] vas_in = 8'ha5;
	logic [7:0] gen_in = 8'hff; // top bits must read zero
	logic [tuner_i2c_pkg::NUM_REGS-1:0][7:0] config_regs;
	logic wr_pulse, osc_sel, cmd_ready, wr_take, rd_valid, done, nack_error;
	logic [7:0] wr_index, rd_data, wr_data, wr_byte;
	logic cmd_valid = 1'b0;
	logic cmd_read = 1'b0;
	logic [7:0] cmd_index = 8'h00;
	logic [4:0] cmd_len = 5'h00;
	logic [7:0] wbuf [5]; // bytes handed out on each wr_take
	logic [7:0] rq [$]; // bytes returned by the master
	int wp = 0, wcount = 0, acount = 0, cyc = 0, bad_count = 0, checks_done = 0;
	assign wr_data = wbuf[wp];
	tuner_i2c_if link ();
	tuner_i2c_slave tuner_i2c_slave_i (.clk_sys(clk_sys), .rstn(rstn), .link(link),
		.address_strap_bit_hi(strap[1]), .address_strap_bit_lo(strap[0]),
		.rom_readback_in(rom_in), .autoselect_status_in(vas_in), .general_status_in(gen_in),
		.config_regs(config_regs), .reg_write_pulse(wr_pulse), .reg_write_index(wr_index),
		.reg_write_data(wr_byte), .oscillator_autoselect(osc_sel));
	tuner_i2c_master tuner_i2c_master_i (.clk_sys(clk_sys), .rstn(rstn), .link(link),
		.cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_index(cmd_index), .cmd_len(cmd_len),
		.cmd_ready(cmd_ready), .wr_data(wr_data), .wr_take(wr_take), .rd_valid(rd_valid),
		.rd_data(rd_data), .done(done), .nack_error(nack_error));
	tuner_i2c_register_port_asserts tuner_i2c_register_port_asserts_i (.clk_sys(clk_sys),
		.rstn(rstn), .scl(link.scl), .sda(link.sda), .m_scl_oe(link.m_scl_oe),
		.m_sda_oe(link.m_sda_oe), .s_sda_oe(link.s_sda_oe));
	// ****************************************
	// clock, monitors and watchdog
	// ****************************************
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	// ceiling well above the ~40k cycles the tests need
	// pulses are counted on the falling edge, where they are settled
	always @(negedge clk_sys) begin
		cyc++;
		if (rd_valid === 1'b1) rq.push_back(rd_data);
		if (wr_take === 1'b1) wp <= wp + 1;
		if (wr_pulse === 1'b1) wcount++;
		if (osc_sel === 1'b1) acount++;
		if (cyc == 90000) begin
			bad_count++;
			close_out();
		end
	end
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// one command through the master, held until accepted, then wait for done
	task automatic run(input logic rd, input logic [7:0] idx, input logic [4:0] len);
		wp <= 0;
		rq.delete();
		@(negedge clk_sys);
		while (cmd_ready !== 1'b1) @(negedge clk_sys);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_read <= rd;
		cmd_index <= idx;
		cmd_len <= len;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		@(negedge clk_sys);
		while (done !== 1'b1) @(negedge clk_sys);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_write;
		wbuf = '{8'h0e, 8'hd8, 8'he1, 8'h00, 8'h00};
		wcount = 0;
		run(1'b0, 8'h00, 5'h03);
		`CHK(config_regs[0], 8'h0e)
		`CHK(config_regs[1], 8'hd8)
		`CHK(config_regs[2], 8'he1)
		`CHK(wcount, 3)
		`CHK(wr_index, 8'h02)
		`CHK(wr_byte, 8'he1)
		`CHK(nack_error, 1'b0)
		$display("t_write done");
	endtask
	task t_autosel;
		// channel registers rewritten in ascending order; only the last triggers
		wbuf = '{8'h0e, 8'hd8, 8'he1, 8'h26, 8'h66};
		acount = 0;
		run(1'b0, 8'h00, 5'h05);
		`CHK(acount, 1)
		`CHK(config_regs[4], 8'h66)
		`CHK(config_regs[3], 8'h26)
		$display("t_autosel done");
	endtask
	task t_read;
		run(1'b1, 8'h00, 5'h03);
		`CHK(rq.size(), 3)
		`CHK(rq[0], 8'h0e)
		`CHK(rq[1], 8'hd8)
		`CHK(rq[2], 8'he1)
		$display("t_read done");
	endtask
	task t_readonly;
		wbuf[0] = 8'hff;
		run(1'b0, 8'h11, 5'h01);
		`CHK(nack_error, 1'b1)
		run(1'b1, 8'h10, 5'h03);
		`CHK(rq[0], rom_in)
		`CHK(rq[1], vas_in)
		`CHK(rq[2], gen_in & tuner_i2c_pkg::GENERAL_STATUS_MASK)
		run(1'b1, 8'h14, 5'h01);
		`CHK(rq[0], 8'h00)
		$display("t_readonly done");
	endtask
	task t_unused;
		wbuf = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
		run(1'b0, 8'h07, 5'h03);
		`CHK(config_regs[7], tuner_i2c_pkg::WRITE_MASK[7])
		`CHK(config_regs[8], 8'hff)
		`CHK(config_regs[9], tuner_i2c_pkg::WRITE_MASK[9])
		$display("t_unused done");
	endtask
	// strap codes 01 and 10 give other addresses and 11 matches none, so the master is refused
	task t_strap;
		for (int s = 1; s < 4; s++) begin
			@(posedge clk_sys);
			strap <= s[1:0];
			repeat (8) @(posedge clk_sys);
			wbuf[0] = 8'h77;
			run(1'b0, 8'h00, 5'h01);
			`CHK(nack_error, 1'b1)
			`CHK(config_regs[0], 8'h0e)
		end
		@(posedge clk_sys);
		strap <= 2'h0;
		$display("t_strap done");
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		`CHK(config_regs[5], tuner_i2c_pkg::REG_RESET)
		`CHK(cmd_ready, 1'b0)
		t_write();
		t_autosel();
		t_read();
		t_readonly();
		t_unused();
		t_strap();
		close_out();
	end
endmodule
